// ---- hdl/rsi_top.sv ----
// Purpose: reset source merge, reset sequencing and supply warning control
// Assumes: analog comparators deliver digital levels asynchronous to clk
// Notes: option settings are static straps from non-volatile storage
`timescale 1ns/1ps
module rsi_top
  import rsi_pkg::*;
(
  clk,
  rst_b,
  resetPinIn,
  resetPinOut,
  resetPinOe_b,
  undervoltLow,
  warnCompLow,
  watchdogUnderflow,
  illegalOpcode,
  uvEnableOpt,
  uvThresholdOpt,
  uvThresholdSel,
  lowFreqClock,
  haltMode,
  waitMode,
  globalMaskSet,
  irqAck,
  regAddr,
  regWdata,
  regWr,
  regRd,
  regRdata,
  cpuRst_b,
  vectorFetch,
  warnIrq,
  wakeFromWait
);
  input wire logic clk;
  input wire logic rst_b;
  input wire logic resetPinIn;
  output logic resetPinOut;
  output logic resetPinOe_b;
  input wire logic undervoltLow;
  input wire logic warnCompLow;
  input wire logic watchdogUnderflow;
  input wire logic illegalOpcode;
  input wire logic uvEnableOpt;
  input wire logic [1:0] uvThresholdOpt;
  output logic [1:0] uvThresholdSel;
  input wire logic lowFreqClock;
  input wire logic haltMode;
  input wire logic waitMode;
  input wire logic globalMaskSet;
  input wire logic irqAck;
  input wire logic [1:0] regAddr;
  input wire logic [7:0] regWdata;
  input wire logic regWr;
  input wire logic regRd;
  output logic [7:0] regRdata;
  output logic cpuRst_b;
  output logic vectorFetch;
  output logic warnIrq;
  output logic wakeFromWait;

  // ==========================================================
  // Reset source merge
  logic uvActive;
  logic rawRstB;
  logic sysRstB;
  logic pulseDone;
  rsi_state_t state_q, state_d;
  logic [CntW-1:0] cnt_q, cnt_d;
  logic [CntW-1:0] delayLen;
  logic wdCaught_q;
  logic uvCaught_q;
  logic extPinLow;
  logic releaseQ_q;

  assign uvActive = uvEnableOpt & undervoltLow;
  assign uvThresholdSel = uvThresholdOpt;
  // Pin and undervoltage act without clock so Halt cannot block them
  assign rawRstB = rst_b & ~extPinLow & ~uvActive;

  rsi_rst_sync u_rstSync (
    .clk(clk),
    .rawRstB(rawRstB),
    .sysRstB(sysRstB)
  );

  // ==========================================================
  // Synchronised inputs
  logic warnSync;
  logic uvSync;
  rsi_sync u_warnSync (
    .clk(clk),
    .rst_b(rst_b),
    .din(warnCompLow),
    .dout(warnSync)
  );
  rsi_sync u_uvSync (
    .clk(clk),
    .rst_b(rst_b),
    .din(uvActive),
    .dout(uvSync)
  );

  // ==========================================================
  // Internal sources, caught on the clock before pin pulls low
  logic intTrigger;
  assign intTrigger = watchdogUnderflow | illegalOpcode;

  // ==========================================================
  // Sequencer
  assign delayLen = lowFreqClock ? CntW'(DelayShortCyc) : CntW'(DelayLongCyc);
  assign pulseDone = (cnt_q >= CntW'(MinIntPulseCyc - 1));

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      RSI_ACTIVE: begin
        cnt_d = cnt_q + CntW'(1);
        if (pulseDone) begin
          state_d = RSI_DELAY;
          cnt_d = '0;
        end
      end
      RSI_DELAY: begin
        cnt_d = cnt_q + CntW'(1);
        if (cnt_q == delayLen - CntW'(1)) begin
          state_d = RSI_FETCH;
          cnt_d = '0;
        end
      end
      RSI_FETCH: begin
        cnt_d = cnt_q + CntW'(1);
        if (cnt_q == CntW'(FetchCyc - 1)) begin
          state_d = RSI_RUN;
          cnt_d = '0;
        end
      end
      RSI_RUN: begin
        if (intTrigger) begin
          state_d = RSI_ACTIVE;
          cnt_d = '0;
        end
      end
      default: begin
        state_d = RSI_ACTIVE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge sysRstB) begin
    if (!sysRstB) begin
      state_q <= RSI_ACTIVE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // Phase decode
  logic inActive;
  logic inDelay;
  logic inFetch;
  logic inRun;
  assign inActive = (state_q == RSI_ACTIVE);
  assign inDelay = (state_q == RSI_DELAY);
  assign inFetch = (state_q == RSI_FETCH);
  assign inRun = (state_q == RSI_RUN);

  // Pin pulled low for active and delay phases, never driven high
  logic pullLow;
  assign pullLow = ~sysRstB | uvActive | inActive | inDelay;
  assign resetPinOut = 1'b0;
  assign resetPinOe_b = ~pullLow;
  assign cpuRst_b = inRun | inFetch;
  assign vectorFetch = inFetch;

  // ==========================================================
  // Pin sense
  // Own pull masks the sense, else the block would hold itself in reset
  // Sense resumes one edge after release, so the pin's rise cannot glitch it
  assign extPinLow = ~resetPinIn & ~pullLow & releaseQ_q;
  always_ff @(posedge clk or negedge sysRstB) begin
    if (!sysRstB) begin
      releaseQ_q <= 1'b0;
    end else begin
      releaseQ_q <= ~pullLow;
    end
  end

  // ==========================================================
  // Reset cause capture, survives internal reset
  logic wdEvent;
  assign wdEvent = watchdogUnderflow & inRun;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdCaught_q <= 1'b0;
      uvCaught_q <= 1'b0;
    end else begin
      wdCaught_q <= wdEvent & ~uvSync;
      uvCaught_q <= uvSync;
    end
  end

  // ==========================================================
  // Integrity status and control register
  logic irqEn_q, irqEn_d;
  logic wdFlag_q, wdFlag_d;
  logic uvFlag_q, uvFlag_d;
  logic [1:0] cal_q, cal_d;
  logic [1:0] thr_q, thr_d;
  logic warnPrev_q;
  logic pend_q, pend_d;
  logic [7:0] rdata_d;
  logic wrInteg;
  logic wrThr;
  logic rdInteg;
  logic crossing;

  logic selInteg;
  logic selThr;

  function automatic logic addrHit(input logic [1:0] addr, input logic [1:0] want);
    return addr == want;
  endfunction

  assign selInteg = addrHit(regAddr, AddrIntegrity);
  assign selThr = addrHit(regAddr, AddrThreshold);
  assign wrInteg = regWr & selInteg & ~haltMode;
  assign wrThr = regWr & selThr;
  assign rdInteg = regRd & selInteg & ~haltMode;
  assign crossing = warnSync ^ warnPrev_q;

  always_comb begin
    irqEn_d = irqEn_q;
    cal_d = cal_q;
    wdFlag_d = wdFlag_q;
    uvFlag_d = uvFlag_q;
    thr_d = thr_q;
    pend_d = pend_q;
    if (wrInteg) begin
      irqEn_d = regWdata[BitIrqEn];
      cal_d = regWdata[CalHi:CalLo];
      if (!regWdata[BitWdFlag]) begin
        wdFlag_d = 1'b0;
      end
    end
    if (rdInteg) begin
      uvFlag_d = 1'b0;
    end
    if (wdCaught_q) begin
      wdFlag_d = 1'b1;
    end
    if (uvCaught_q) begin
      uvFlag_d = 1'b1;
      wdFlag_d = 1'b0;
    end
    if (wrThr) begin
      thr_d = regWdata[ThrHi:ThrLo];
    end
    if (irqAck) begin
      pend_d = 1'b0;
    end
    // Set wins over acknowledge
    if (crossing && irqEn_q) begin
      pend_d = 1'b1;
    end
    if (haltMode) begin
      irqEn_d = irqEn_q;
      cal_d = cal_q;
      wdFlag_d = wdFlag_q;
      uvFlag_d = uvFlag_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqEn_q <= IntegrityRst[BitIrqEn];
      cal_q <= IntegrityRst[CalHi:CalLo];
      wdFlag_q <= IntegrityRst[BitWdFlag];
      uvFlag_q <= IntegrityRst[BitUvFlag];
      thr_q <= ThresholdRst[ThrHi:ThrLo];
      warnPrev_q <= 1'b0;
      pend_q <= 1'b0;
      regRdata <= 8'h00;
    end else begin
      irqEn_q <= irqEn_d;
      cal_q <= cal_d;
      wdFlag_q <= wdFlag_d;
      uvFlag_q <= uvFlag_d;
      thr_q <= sysRstB ? thr_d : ThresholdRst[ThrHi:ThrLo];
      // Detector stays active in Halt
      warnPrev_q <= warnSync;
      pend_q <= pend_d;
      regRdata <= rdata_d;
    end
  end

  // ==========================================================
  // Read mux
  logic [7:0] integView;
  logic [7:0] thrView;
  logic [7:0] causeView;
  assign integView = {1'b0, cal_q, wdFlag_q, 1'b0, uvFlag_q, warnSync, irqEn_q};
  assign thrView = {6'h00, thr_q};
  assign causeView = {4'h0, state_q};
  always_comb begin
    case (regAddr)
      AddrIntegrity: rdata_d = regRd ? integView : 8'h00;
      AddrThreshold: rdata_d = regRd ? thrView : 8'h00;
      AddrCause: rdata_d = regRd ? causeView : 8'h00;
      default: rdata_d = 8'h00;
    endcase
  end

  // ==========================================================
  // Interrupt delivery
  assign warnIrq = pend_q & irqEn_q & ~globalMaskSet & ~haltMode;
  assign wakeFromWait = warnIrq & waitMode;
endmodule

// ---- hdl/rsi_pkg.sv ----
// Purpose: shared constants for the reset and supply integrity block
// Assumes: 40 MHz processor clock
// Notes: register offsets are local to this block
package rsi_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned ClkMhz = 40;
  localparam int unsigned MinIntPulseNs = 1000;
  localparam int unsigned MinIntPulseCyc = (MinIntPulseNs * ClkMhz + 999) / 1000;
  localparam int unsigned DelayLongCyc = 4096;
  localparam int unsigned DelayShortCyc = 256;
  localparam int unsigned FetchCyc = 2;
  localparam int unsigned CntW = 13;
  // ==========================================================
  // Register map
  localparam logic [1:0] AddrIntegrity = 2'h0;
  localparam logic [1:0] AddrThreshold = 2'h1;
  localparam logic [1:0] AddrCause = 2'h2;
  localparam logic [7:0] IntegrityRst = 8'h60;
  localparam logic [7:0] ThresholdRst = 8'h03;
  localparam int unsigned BitIrqEn = 0;
  localparam int unsigned BitWarnFlag = 1;
  localparam int unsigned BitUvFlag = 2;
  localparam int unsigned BitWdFlag = 4;
  localparam int unsigned CalLo = 5;
  localparam int unsigned CalHi = 6;
  localparam int unsigned ThrLo = 0;
  localparam int unsigned ThrHi = 1;
  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    RSI_ACTIVE = 4'h1,
    RSI_DELAY = 4'h2,
    RSI_FETCH = 4'h4,
    RSI_RUN = 4'h8
  } rsi_state_t;
endpackage

// ---- hdl/rsi_sync.sv ----
// Purpose: two-flop synchroniser with asynchronous preset-free reset
// Assumes: input from another clock domain or a pin
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module rsi_sync (
  clk,
  rst_b,
  din,
  dout
);
  input wire logic clk;
  input wire logic rst_b;
  input wire logic din;
  output logic dout;
  logic meta_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ---- hdl/rsi_rst_sync.sv ----
// Purpose: asynchronous assert, synchronous release of internal reset
// Assumes: rawRstB drops without a clock
// Notes: output low as soon as any source merged into rawRstB asserts
`timescale 1ns/1ps
module rsi_rst_sync (
  clk,
  rawRstB,
  sysRstB
);
  input wire logic clk;
  input wire logic rawRstB;
  output logic sysRstB;
  logic stage_q;
  // ==========================================================
  // Release after two edges
  always_ff @(posedge clk or negedge rawRstB) begin
    if (!rawRstB) begin
      stage_q <= 1'b0;
      sysRstB <= 1'b0;
    end else begin
      stage_q <= 1'b1;
      sysRstB <= stage_q;
    end
  end
endmodule

// ---- tb/rsi_top_assertions.sv ----
// Purpose: port checks for reset and supply integrity
// Assumes: one clock domain
// Notes: pin pulse length held in a counter
`timescale 1ns/1ps
module rsi_top_assertions
  import rsi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic resetPinOut,
  input wire logic resetPinOe_b,
  input wire logic undervoltLow,
  input wire logic uvEnableOpt,
  input wire logic [1:0] uvThresholdOpt,
  input wire logic [1:0] uvThresholdSel,
  input wire logic haltMode,
  input wire logic globalMaskSet,
  input wire logic cpuRst_b,
  input wire logic vectorFetch,
  input wire logic warnIrq,
  input wire logic wakeFromWait
);
  // ==========================================================
  // Helpers
  logic [12:0] lowCnt_q;
  logic [12:0] lowCnt_d;
  // Saturates so a stuck pin cannot wrap
  assign lowCnt_d = resetPinOe_b ? 13'h0000 : lowCnt_q + {12'h000, ~&lowCnt_q};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) lowCnt_q <= 13'h0000;
    else lowCnt_q <= lowCnt_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence fetchPair;
    vectorFetch [*2] ##1 !vectorFetch;
  endsequence
  // ==========================================================
  // Checks
  chk_pin_low_only: assert property (resetPinOut == 1'b0)
    else $error("reset pin driven high");
  chk_uv_holds_pin: assert property ((undervoltLow && uvEnableOpt) [*6] |-> !resetPinOe_b)
    else $error("undervolt without pin low");
  chk_thr_passthru: assert property (uvThresholdSel == uvThresholdOpt)
    else $error("threshold strap lost");
  chk_rst_holds_pin: assert property (!cpuRst_b |-> !resetPinOe_b)
    else $error("pin released in reset");
  chk_fetch_two: assert property ($rose(cpuRst_b) |-> fetchPair)
    else $error("fetch not two cycles");
  chk_pulse_len: assert property ($rose(resetPinOe_b) |-> lowCnt_q >= 13'(DelayShortCyc))
    else $error("pin low pulse short");
  chk_irq_masked: assert property (warnIrq |-> !globalMaskSet)
    else $error("irq through mask");
  chk_halt_no_wake: assert property (haltMode |-> !wakeFromWait)
    else $error("wake in halt");
endmodule
bind rsi_top rsi_top_assertions u_chk (.clk(clk), .rst_b(rst_b), .resetPinOut(resetPinOut),
  .resetPinOe_b(resetPinOe_b), .undervoltLow(undervoltLow), .uvEnableOpt(uvEnableOpt),
  .uvThresholdOpt(uvThresholdOpt), .uvThresholdSel(uvThresholdSel), .haltMode(haltMode),
  .globalMaskSet(globalMaskSet), .cpuRst_b(cpuRst_b), .vectorFetch(vectorFetch),
  .warnIrq(warnIrq), .wakeFromWait(wakeFromWait));

// ---- tb/rsi_pin_model.sv ----
// Purpose: board reset circuit on the open-drain pin
// Assumes: weak pull-up when nobody pulls
// Notes: requests stretched to minimum pulse
`timescale 1ns/1ps
module rsi_pin_model #(
  parameter int MinExtCyc = 4
) (
  input wire logic clk,
  input wire logic pullReq,
  input wire logic devOe_b,
  output logic pinLevel
);
  // ==========================================================
  // Pin
  int holdCnt = 0;
  always @(posedge clk) begin
    if (pullReq) holdCnt <= MinExtCyc;
    else if (holdCnt > 0) holdCnt <= holdCnt - 1;
  end
  // Wired low: pull-up only wins when all release
  assign pinLevel = (!devOe_b || holdCnt > 0) ? 1'b0 : 1'b1;
endmodule

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the integrity block
// Assumes: short delay strap for run time
// Notes: reads checked through a queue
`timescale 1ns/1ps
module tb;
  import rsi_pkg::*;
  // ==========================================================
  // Bench
  logic clk = 0, rst_b = 0, extPull = 0, pinLevel, resetPinOut, resetPinOe_b;
  logic cpuRst_b, vectorFetch, warnIrq, wakeFromWait, prevRd = 0;
  logic undervoltLow = 0, warnCompLow = 0, watchdogUnderflow = 0, illegalOpcode = 0;
  logic uvEnableOpt = 1, lowFreqClock = 1, haltMode = 0, waitMode = 0;
  logic globalMaskSet = 0, irqAck = 0, regWr = 0, regRd = 0;
  logic [1:0] uvThresholdOpt = 2'h2, uvThresholdSel, regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [31:0] seed = 32'hE0B33CA1;
  logic [7:0] expQ[$];
  int n_fail = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  rsi_top dut (.clk(clk), .rst_b(rst_b), .resetPinIn(pinLevel), .resetPinOut(resetPinOut),
    .resetPinOe_b(resetPinOe_b), .undervoltLow(undervoltLow), .warnCompLow(warnCompLow),
    .watchdogUnderflow(watchdogUnderflow), .illegalOpcode(illegalOpcode),
    .uvEnableOpt(uvEnableOpt), .uvThresholdOpt(uvThresholdOpt), .uvThresholdSel(uvThresholdSel),
    .lowFreqClock(lowFreqClock), .haltMode(haltMode), .waitMode(waitMode),
    .globalMaskSet(globalMaskSet), .irqAck(irqAck), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuRst_b(cpuRst_b),
    .vectorFetch(vectorFetch), .warnIrq(warnIrq), .wakeFromWait(wakeFromWait));
  rsi_pin_model ext (.clk(clk), .pullReq(extPull), .devOe_b(resetPinOe_b), .pinLevel(pinLevel));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Levels are looked at mid-cycle, where outputs have settled
  task automatic settle;
    @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    expQ.push_back(e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  // Bounded wait for the sequencer to reach run
  task automatic wait_run;
    int i;
    tick(4);
    for (i = 0; i < 6000 && cpuRst_b !== 1'b1; i++) @(posedge clk);
    if (i == 6000) begin
      n_fail++;
      wrap_up();
    end
    tick(4);
  endtask
  task automatic reset_cycle;
    int i;
    for (i = 0; i < 20 && pinLevel !== 1'b0; i++) @(negedge clk);
    chk_bit(pinLevel, 1'b0);
    wait_run();
  endtask
  // Read data stand one cycle after the strobe
  always @(negedge clk) begin
    if (prevRd) chk(regRdata, expQ.pop_front());
    prevRd = regRd;
  end
  // ==========================================================
  // Scenarios
  initial begin
    tick(16);
    rst_b <= 1'b1;
    wait_run();
    rd(AddrIntegrity, IntegrityRst);
    rd(AddrThreshold, ThresholdRst);
    rd(AddrCause, {4'h0, RSI_RUN});
    rd(2'h3, 8'h00);
    repeat (4) begin
      seed = lfsr(seed);
      uvThresholdOpt <= seed[3:2];
      wr(AddrThreshold, {6'h00, seed[1:0]});
      rd(AddrThreshold, {6'h00, seed[1:0]});
    end
    $display("test registers done");
    warnCompLow <= 1'b1;
    tick(4);
    rd(AddrIntegrity, 8'h62);
    wr(AddrIntegrity, 8'h61);
    warnCompLow <= 1'b0;
    waitMode <= 1'b1;
    tick(4);
    settle();
    chk_bit(warnIrq, 1'b1);
    chk_bit(wakeFromWait, 1'b1);
    @(posedge clk);
    irqAck <= 1'b1;
    globalMaskSet <= 1'b1;
    @(posedge clk);
    irqAck <= 1'b0;
    warnCompLow <= 1'b1;
    tick(4);
    settle();
    chk_bit(warnIrq, 1'b0);
    @(posedge clk);
    globalMaskSet <= 1'b0;
    settle();
    chk_bit(warnIrq, 1'b1);
    @(posedge clk);
    haltMode <= 1'b1;
    settle();
    chk_bit(warnIrq, 1'b0);
    chk_bit(wakeFromWait, 1'b0);
    wr(AddrIntegrity, 8'h60);
    irqAck <= 1'b1;
    @(posedge clk);
    irqAck <= 1'b0;
    warnCompLow <= 1'b0;
    tick(4);
    haltMode <= 1'b0;
    waitMode <= 1'b0;
    settle();
    chk_bit(warnIrq, 1'b1);
    chk_bit(wakeFromWait, 1'b0);
    rd(AddrIntegrity, 8'h61);
    irqAck <= 1'b1;
    wr(AddrIntegrity, 8'h60);
    irqAck <= 1'b0;
    settle();
    chk_bit(warnIrq, 1'b0);
    $display("test warning done");
    @(posedge clk);
    watchdogUnderflow <= 1'b1;
    @(posedge clk);
    watchdogUnderflow <= 1'b0;
    reset_cycle();
    rd(AddrIntegrity, 8'h70);
    wr(AddrIntegrity, 8'h60);
    rd(AddrIntegrity, 8'h60);
    watchdogUnderflow <= 1'b1;
    @(posedge clk);
    watchdogUnderflow <= 1'b0;
    reset_cycle();
    undervoltLow <= 1'b1;
    tick(20);
    settle();
    chk_bit(pinLevel, 1'b0);
    chk_bit(cpuRst_b, 1'b0);
    @(posedge clk);
    undervoltLow <= 1'b0;
    wait_run();
    extPull <= 1'b1;
    @(posedge clk);
    extPull <= 1'b0;
    reset_cycle();
    rd(AddrIntegrity, 8'h64);
    rd(AddrIntegrity, 8'h60);
    illegalOpcode <= 1'b1;
    @(posedge clk);
    illegalOpcode <= 1'b0;
    reset_cycle();
    rd(AddrIntegrity, 8'h60);
    uvEnableOpt <= 1'b0;
    undervoltLow <= 1'b1;
    tick(20);
    settle();
    chk_bit(pinLevel, 1'b1);
    chk_bit(cpuRst_b, 1'b1);
    @(posedge clk);
    undervoltLow <= 1'b0;
    $display("test resets done");
    tick(4);
    wrap_up();
  end
endmodule
